/* rtl/tap_port.v */
/*
 * Boundary-scan test access port with a small boundary register and an
 * output FIFO of shifted-in data words. Assumes the test clock, mode
 * select and serial input are asynchronous pins sampled by clk_i
 * (20 MHz); the pin pull-ups are not modelled.
 */
`timescale 1ns/1ps
`include "tap_port_consts.vh"

// ==========================================================
// fifo of shifted data-register words
module scan_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_i,    // system clock
  input  wire             sys_rst_i,// async reset
  input  wire [WIDTH-1:0] in_data_i,// write data
  input  wire             in_valid_i,// write valid
  output wire             in_ready_o,// not full
  output reg  [WIDTH-1:0] out_data_o,// head word
  output wire             out_valid_o,// not empty
  input  wire             out_ready_i // drain
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  wire            full  = (wr_q[AW] != rd_q[AW]) &&
                          (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire            empty = (wr_q == rd_q);
  wire            push  = in_valid_i && !full;
  wire            pop   = out_valid_o && out_ready_i;

  assign in_ready_o  = !full;
  assign out_valid_o = !empty;

  // data array written without reset
  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  // pointers with wrap bit for honest full and empty
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end

  // head word presented combinationally from the array
  always @* begin
    out_data_o = mem_q[rd_q[AW-1:0]];
  end
endmodule // scan_fifo

// ==========================================================
// test access port
module tap_port (
  input  wire                clk_i,      // system clock, 20 MHz
  input  wire                sys_rst_i,  // async reset, power-up
  input  wire                tck_i,      // test clock pin
  input  wire                tms_i,      // mode select pin
  input  wire                tdi_i,      // serial data in pin
  output reg                 tdo_o,      // serial data out
  output reg                 tdo_oe_n_o, // low while tdo driven
  input  wire [`BSR_W-1:0]   ring_i,     // pin ring sample
  output reg  [`BSR_W-1:0]   ring_o,     // preload outputs
  output reg                 out_hiz_o,  // float memory outputs
  output wire [`BSR_W-1:0]   word_o,     // fifo head word
  output wire                word_valid_o,// fifo not empty
  input  wire                word_ready_i,// fifo drain
  output reg  [`IR_W-1:0]    ir_o        // active instruction
);
  reg [2:0]          tck_s_q;
  reg [1:0]          tms_s_q;
  reg [1:0]          tdi_s_q;
  reg [3:0]          st_q;
  reg [3:0]          st_d;
  reg [`IR_W-1:0]    irs_q;
  reg [`ID_W-1:0]    dr_q;
  reg [`BSR_W-1:0]   bsr_q;
  reg [2:0]          bcnt_q;
  reg                bsr_full_q;
  wire               fifo_rdy;
  wire               tck_rise = tck_s_q[1] && !tck_s_q[2];
  wire               tck_fall = !tck_s_q[1] && tck_s_q[2];
  wire               tms      = tms_s_q[1];
  wire               tdi      = tdi_s_q[1];
  // bsr shifts do not stall when fifo is full and a word is due
  wire               bsr_sel  = (ir_o == `INS_EXTEST) ||
                                (ir_o == `INS_SAMPLE) ||
                                (ir_o == `INS_SAMPLE_Z);

  // two-flop synchronisers; third tck flop only for edge detect
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tck_s_q <= 3'h0;
      tms_s_q <= 2'h3;
      tdi_s_q <= 2'h3;
    end else begin
      tck_s_q <= {tck_s_q[1:0], tck_i};
      tms_s_q <= {tms_s_q[0], tms_i};
      tdi_s_q <= {tdi_s_q[0], tdi_i};
    end
  end

  // standard state graph; five highs always reach reset
  always @* begin
    case (st_q)
      `ST_RESET:    st_d = tms ? `ST_RESET   : `ST_IDLE;
      `ST_IDLE:     st_d = tms ? `ST_SEL_DR  : `ST_IDLE;
      `ST_SEL_DR:   st_d = tms ? `ST_SEL_IR  : `ST_CAP_DR;
      `ST_CAP_DR:   st_d = tms ? `ST_EXIT1_DR: `ST_SHIFT_DR;
      `ST_SHIFT_DR: st_d = tms ? `ST_EXIT1_DR: `ST_SHIFT_DR;
      `ST_EXIT1_DR: st_d = tms ? `ST_UPD_DR  : `ST_PAUSE_DR;
      `ST_PAUSE_DR: st_d = tms ? `ST_EXIT2_DR: `ST_PAUSE_DR;
      `ST_EXIT2_DR: st_d = tms ? `ST_UPD_DR  : `ST_SHIFT_DR;
      `ST_UPD_DR:   st_d = tms ? `ST_SEL_DR  : `ST_IDLE;
      `ST_SEL_IR:   st_d = tms ? `ST_RESET   : `ST_CAP_IR;
      `ST_CAP_IR:   st_d = tms ? `ST_EXIT1_IR: `ST_SHIFT_IR;
      `ST_SHIFT_IR: st_d = tms ? `ST_EXIT1_IR: `ST_SHIFT_IR;
      `ST_EXIT1_IR: st_d = tms ? `ST_UPD_IR  : `ST_PAUSE_IR;
      `ST_PAUSE_IR: st_d = tms ? `ST_EXIT2_IR: `ST_PAUSE_IR;
      `ST_EXIT2_IR: st_d = tms ? `ST_UPD_IR  : `ST_SHIFT_IR;
      `ST_UPD_IR:   st_d = tms ? `ST_SEL_DR  : `ST_IDLE;
      default:      st_d = `ST_RESET;
    endcase
  end

  // rising-edge work: state, capture, shift, update
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q       <= `ST_RESET;
      ir_o       <= `INS_IDENT;
      irs_q      <= {`IR_W{1'b0}};
      dr_q       <= {`ID_W{1'b0}};
      bsr_q      <= {`BSR_W{1'b0}};
      ring_o     <= {`BSR_W{1'b0}};
      bcnt_q     <= 3'h0;
      bsr_full_q <= 1'b0;
    end else begin
      if (bsr_full_q && fifo_rdy) begin
        bsr_full_q <= 1'b0;
      end
      if (tck_rise) begin
        st_q <= st_d;
        case (st_q)
          `ST_RESET:    ir_o <= `INS_IDENT;
          `ST_CAP_IR:   irs_q <= `IR_CAPTURE;
          `ST_SHIFT_IR: irs_q <= {tdi, irs_q[`IR_W-1:1]};
          `ST_UPD_IR:   ir_o <= irs_q;
          `ST_CAP_DR: begin
            if (ir_o == `INS_IDENT) begin
              dr_q <= `ID_CODE;
            end else if (bsr_sel) begin
              bsr_q  <= ring_i;
              bcnt_q <= 3'h0;
            end else begin
              dr_q[0] <= 1'b0; // bypass captures zero
            end
          end
          `ST_SHIFT_DR: begin
            if (ir_o == `INS_IDENT) begin
              dr_q <= {tdi, dr_q[`ID_W-1:1]};
            end else if (bsr_sel) begin
              bsr_q  <= {tdi, bsr_q[`BSR_W-1:1]};
              bcnt_q <= bcnt_q + 1'b1;
              // a full word goes to the fifo; held pending while it is full
              if (bcnt_q == 3'h7) bsr_full_q <= 1'b1;
            end else begin
              dr_q[0] <= tdi; // single-bit bypass
            end
          end
          `ST_UPD_DR: begin
            if (bsr_sel && ir_o != `INS_SAMPLE_Z) ring_o <= bsr_q;
          end
          default: ;
        endcase
      end
    end
  end

  // memory outputs floated under sample-z or extest with cell low
  always @* begin
    out_hiz_o = (ir_o == `INS_SAMPLE_Z) ||
                ((ir_o == `INS_EXTEST) && !ring_o[`BSR_W-1]);
  end

  // falling-edge output update from the selected LSB
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tdo_o      <= 1'b0;
      tdo_oe_n_o <= 1'b1;
    end else if (tck_fall) begin
      tdo_oe_n_o <= !(st_q == `ST_SHIFT_IR ||
                      st_q == `ST_SHIFT_DR);
      if (st_q == `ST_SHIFT_IR) begin
        tdo_o <= irs_q[0];
      end else if (bsr_sel) begin
        tdo_o <= bsr_q[0];
      end else begin
        tdo_o <= dr_q[0];
      end
    end
  end

  // fifo of completed boundary words for the system side
  scan_fifo #(
    .WIDTH (`BSR_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   (bsr_q),
    .in_valid_i  (bsr_full_q),
    .in_ready_o  (fifo_rdy),
    .out_data_o  (word_o),
    .out_valid_o (word_valid_o),
    .out_ready_i (word_ready_i)
  );
endmodule // tap_port

/* rtl/tap_port_consts.vh */
/*
 * Constants for the boundary-scan test access port: controller state codes,
 * instruction codes, register widths and the identification code.
 * Assumes it is included by bare name from the design file.
 */
`ifndef TAP_PORT_CONSTS_VH
`define TAP_PORT_CONSTS_VH

// ==========================================================
// controller states
`define ST_RESET      4'h0
`define ST_IDLE       4'h1
`define ST_SEL_DR     4'h2
`define ST_CAP_DR     4'h3
`define ST_SHIFT_DR   4'h4
`define ST_EXIT1_DR   4'h5
`define ST_PAUSE_DR   4'h6
`define ST_EXIT2_DR   4'h7
`define ST_UPD_DR     4'h8
`define ST_SEL_IR     4'h9
`define ST_CAP_IR     4'hA
`define ST_SHIFT_IR   4'hB
`define ST_EXIT1_IR   4'hC
`define ST_PAUSE_IR   4'hD
`define ST_EXIT2_IR   4'hE
`define ST_UPD_IR     4'hF

// ==========================================================
// instructions and widths
`define IR_W          3
`define INS_EXTEST    3'h0
`define INS_IDENT     3'h1
`define INS_SAMPLE_Z  3'h2
`define INS_SAMPLE    3'h4
`define INS_BYPASS    3'h7
`define IR_CAPTURE    3'h1
`define ID_W          32
// identification code: arbitrary neutral value
`define ID_CODE       32'h0000_0001
`define BSR_W         8
`define FIFO_DEPTH    8

`endif

/* verif/jtag_host.sv */
/* Board tester model driving the test port pins.
   Assumes a free-running system clock to pace its steps. */
`timescale 1ns/1ps
// ==========================================================
// tester
module jtag_host (
  input  wire clk_i, // pacing clock
  input  wire tdo_i, // serial out of port
  output reg  tck_o, // test clock, 450 ns
  output reg  tms_o, // mode select
  output reg  tdi_o  // serial data
);
  // tck parked low between frames; tms starts high
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // one tck period; tdo taken at the rise
  task step(input m, input d, output q);
    begin
      @(posedge clk_i) #1 tms_o = m;
      tdi_o = d;
      repeat (4) @(posedge clk_i);
      #1 tck_o = 1'b1;
      q = tdo_i;
      repeat (4) @(posedge clk_i);
      #1 tck_o = 1'b0;
    end
  endtask
  // tms path, lsb first; tdi toggles so stale data never looks valid
  task walk(input [7:0] p, input integer n);
    integer i;
    reg     q;
    for (i = 0; i < n; i++)
      step(p[i], ~tdi_o, q);
  endtask
  // shift n bits lsb first, leaving on the last
  task scan(input integer n, input [31:0] din, output [31:0] dout);
    integer i;
    reg     q;
    dout = 32'h0;
    for (i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
  endtask
endmodule // jtag_host

/* verif/tap_port_properties.sv */
/* Checker for tap_port, sees only its ports.
   Assumes tck held >= 4 clk each phase. */
`timescale 1ns/1ps
`include "tap_port_consts.vh"
// ==========================================================
// checker
module tap_port_checker (
  input wire              clk_i,        // system clock
  input wire              sys_rst_i,    // async reset
  input wire              tck_i,        // test clock pin
  input wire              tms_i,        // mode select pin
  input wire              tdo_o,        // serial out
  input wire              tdo_oe_n_o,   // serial out enable
  input wire [`BSR_W-1:0] ring_o,       // preload outputs
  input wire              out_hiz_o,    // float outputs
  input wire [`BSR_W-1:0] word_o,       // fifo head
  input wire              word_valid_o, // fifo not empty
  input wire              word_ready_i, // fifo drain
  input wire [`IR_W-1:0]  ir_o          // instruction
);
  reg       tck_d_q;
  reg [2:0] hi_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // count tck rises with tms high, saturating
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tck_d_q <= 1'b0;
      hi_q    <= 3'h0;
    end else begin
      tck_d_q <= tck_i;
      if (tck_i && !tck_d_q)
        hi_q <= !tms_i ? 3'h0 : (hi_q == 3'h7 ? hi_q : hi_q + 3'h1);
    end
  end
  a_reset_state: assert property ($fell(sys_rst_i) |->
    ir_o == `INS_IDENT && tdo_oe_n_o) else $error("bad reset state");
  a_tdo_on_fall: assert property ($changed(tdo_o) |->
    !$past(tck_i, 2)) else $error("tdo moved with tck high");
  a_oe_on_fall: assert property ($changed(tdo_oe_n_o) |->
    !$past(tck_i, 2)) else $error("tdo enable moved with tck high");
  // instruction only moves on a sampled rising test clock
  a_ir_on_rise: assert property ($changed(ir_o) |->
    $past(tck_i, 2)) else $error("instruction moved with tck low");
  // six highs: reset reached and instruction reloaded by the sixth
  a_tms_reset: assert property (hi_q == 3'h6 |-> ##4
    ir_o == `INS_IDENT && tdo_oe_n_o) else $error("tms reset missed");
  a_hiz_samplez: assert property (ir_o == `INS_SAMPLE_Z |->
    out_hiz_o) else $error("outputs not floated");
  a_hiz_extest: assert property (ir_o == `INS_EXTEST |->
    out_hiz_o == !ring_o[7]) else $error("extest float wrong");
  a_hiz_other: assert property (ir_o[1:0] != 2'h0 && ir_o != 3'h2 |->
    !out_hiz_o) else $error("outputs floated");
  a_word_hold: assert property (word_valid_o && !word_ready_i |=>
    word_valid_o && $stable(word_o)) else $error("word lost");
  c_bypass: cover property (ir_o == `INS_BYPASS);
  c_word: cover property ($rose(word_valid_o));
  c_tms_reset: cover property (hi_q == 3'h6);
endmodule // tap_port_checker

bind tap_port tap_port_checker chk_u (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .tck_i(tck_i), .tms_i(tms_i), .tdo_o(tdo_o),
  .tdo_oe_n_o(tdo_oe_n_o), .ring_o(ring_o), .out_hiz_o(out_hiz_o),
  .word_o(word_o), .word_valid_o(word_valid_o),
  .word_ready_i(word_ready_i), .ir_o(ir_o));

/* verif/tap_port_test.sv */
/* Self-checking bench for tap_port with a tester model.
   Assumes the port's header constants. */
`timescale 1ns/1ps
`include "tap_port_consts.vh"
module tap_port_test;
  reg               clk_i = 1'b0;
  reg               sys_rst_i = 1'b1;
  reg  [`BSR_W-1:0] ring_i = 8'hA5;
  reg               word_ready_i = 1'b0;
  wire              tck, tms, tdi, tdo, tdo_oe_n_o, out_hiz_o, word_valid_o;
  wire [`BSR_W-1:0] ring_o, word_o;
  wire [`IR_W-1:0]  ir_o;
  wire              tdo_w = tdo_oe_n_o ? 1'bz : tdo;
  integer           n_errors = 0;
  integer           checks = 0;
  reg  [31:0]       r;
  integer           k;
  always #25 clk_i = ~clk_i;
  tap_port dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .tck_i(tck),
    .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n_o),
    .ring_i(ring_i), .ring_o(ring_o), .out_hiz_o(out_hiz_o),
    .word_o(word_o), .word_valid_o(word_valid_o),
    .word_ready_i(word_ready_i), .ir_o(ir_o));
  jtag_host host_u (.clk_i(clk_i), .tdo_i(tdo_w), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi));
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks++;
      if (seen !== exp) begin
        n_errors++;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      if (n_errors == 0 && checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // load an instruction, checking the capture pattern on the way
  task load_ir(input [2:0] v);
    begin
      host_u.walk(8'h03, 4);
      host_u.scan(3, {29'h0, v}, r);
      chk(r[1:0], 2'h1);
      host_u.walk(8'h01, 2);
      chk(ir_o, v);
    end
  endtask
  task t_bypass;
    begin
      load_ir(`INS_BYPASS);
      host_u.walk(8'h01, 3);
      host_u.scan(8, 32'hB4, r);
      chk(r, 32'h68);
      host_u.walk(8'h01, 2);
    end
  endtask
  // boundary path: capture, preload and output float control
  task t_ring;
    begin
      load_ir(`INS_SAMPLE);
      chk(out_hiz_o, 1'b0);
      host_u.walk(8'h01, 3);
      host_u.scan(8, 32'h3C, r);
      chk(r, 32'hA5);
      host_u.walk(8'h01, 2);
      chk(ring_o, 8'h3C);
      load_ir(`INS_EXTEST);
      chk(out_hiz_o, 1'b1);
      load_ir(`INS_SAMPLE_Z);
      chk(out_hiz_o, 1'b1);
    end
  endtask
  // one word waits; eight more overflow the fifo, then drain it
  task t_fifo;
    begin
      for (k = 0; k < 8; k++) begin
        host_u.walk(8'h01, 3);
        host_u.scan(8, k, r);
        host_u.walk(8'h01, 2);
      end
      @(posedge clk_i) #1 word_ready_i = 1'b1;
      k = 0;
      // the ninth word waits behind the full fifo and follows the rest
      repeat (20) begin
        if (word_valid_o === 1'b1) begin
          chk(word_o, (k == 0) ? 32'h3C : k - 1);
          k++;
        end
        @(posedge clk_i) #1;
      end
      word_ready_i = 1'b0;
      chk(k, 9);
      chk(word_valid_o, 1'b0);
    end
  endtask
  // tms reset, then the identification code
  task t_id;
    begin
      host_u.walk(8'h3F, 7);
      chk(ir_o, `INS_IDENT);
      chk(tdo_oe_n_o, 1'b1);
      host_u.walk(8'h01, 3);
      repeat (5) @(posedge clk_i);
      chk(tdo_oe_n_o, 1'b0);
      host_u.scan(32, 32'h0, r);
      chk(r, `ID_CODE);
      host_u.walk(8'h01, 2);
    end
  endtask
  // watchdog
  initial begin
    #2000000;
    n_errors++;
    results;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    chk(ir_o, `INS_IDENT);
    chk(tdo_oe_n_o, 1'b1);
    // leave the reset state for idle before the first instruction
    host_u.walk(8'h00, 1);
    t_bypass;
    t_ring;
    t_fifo;
    t_id;
    results;
  end
endmodule // tap_port_test
